// ### cea_map.svh
// named constants of the execution anomaly block: offsets, field positions, reset values
// assumes inclusion by bare name from every file that needs the figures
`ifndef CEA_MAP_SVH
`define CEA_MAP_SVH

`define CEA_AW          20
`define CEA_ADDR_RST    20'h00000
`define CEA_PUSH_A_DEC  20'h00004
`define CEA_PUSH_W_DEC  20'h00002
`define CEA_CALL_PC_OFS 20'h00002
`define CEA_BIT_OPC_LEN 20'h00002
`define CEA_REG_PC      4'h0
`define CEA_REG_SP      4'h1
`define CEA_FLAG_C      0
`define CEA_FLAG_Z      1
`define CEA_FLAG_N      2
`define CEA_FLAG_V      3
`define CEA_FLAGS_RST   4'h0
`define CEA_TR_AW       4
`define CEA_TR_DEPTH    16
`define CEA_PTR_RST     4'h0

`endif

// ### cea_pkg.sv
// types shared by the execution anomaly block: instruction classes, modes, run state
// assumes the decoder upstream already sorts each instruction into one class
package cea_pkg;

  typedef enum logic [3:0] {
    cea_op_nop                 = 4'h0,
    cea_op_stack_store_addr_ext = 4'h1,
    cea_op_stack_store_word    = 4'h2,
    cea_op_subroutine_jump_20bit = 4'h3,
    cea_op_branch_cond         = 4'h4,
    cea_op_rotate_shift_multi  = 4'h5,
    cea_op_bit_test            = 4'h6,
    cea_op_other               = 4'h7
  } cea_op_e;

  typedef enum logic [2:0] {
    cea_md_register = 3'h0,
    cea_md_indexed  = 3'h1,
    cea_md_symbolic = 3'h2,
    cea_md_absolute = 3'h3,
    cea_md_indirect = 3'h4,
    cea_md_ind_inc  = 3'h5,
    cea_md_immed    = 3'h6
  } cea_mode_e;

  typedef enum logic [1:0] {
    cea_st_run  = 2'b01,
    cea_st_halt = 2'b10
  } cea_st_e;

endpackage

// ### cea_trace_mem.sv
// trace state storage: one write port, one read port with registered read data
// assumes a single clock and that writes and reads may fall in the same cycle
`include "cea_map.svh"
`timescale 1ns/10ps
module cea_trace_mem (
  input  wire logic                    mclk,
  input  wire logic                    rstn,
  input  wire logic                    wr_en,
  input  wire logic [`CEA_TR_AW-1:0]   wr_addr,
  input  wire logic [`CEA_AW-1:0]      wr_data,
  input  wire logic [`CEA_TR_AW-1:0]   rd_addr,
  output logic      [`CEA_AW-1:0]      rd_data_r
);

  logic [`CEA_AW-1:0] mem [`CEA_TR_DEPTH];

  // storage array, no reset needed
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data always from a flop
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_data_r <= `CEA_ADDR_RST;
    end else begin
      rd_data_r <= mem[rd_addr];
    end
  end

endmodule

// ### cea_exec.sv
// bug-compatible execution of the anomalous instruction cases plus the trace recorder
// assumes one retired instruction per ins_valid pulse, with operands valid alongside it
// Functional notes
// - push addr @sp+ loads sp from stack word
// - call via program counter saves return minus two
// - sp-indexed call after memory push: index unsigned
// - register/immediate push or other base: sign-extended
// - untaken branch then rotate on pc halts
// - bit @rx,pc omits opcode bytes, sets flags
// - trace records wrong sequence in branch loops
// - loop exit traces loop head as next
`include "cea_map.svh"
`timescale 1ns/10ps
module cea_exec #(
  parameter bit ANOM_SP_PUSH  = 1'b1,
  parameter bit ANOM_CALL_PC  = 1'b1,
  parameter bit ANOM_CALL_IDX = 1'b1,
  parameter bit ANOM_ROT_HALT = 1'b1,
  parameter bit ANOM_BIT_PC   = 1'b1,
  parameter bit ANOM_TRACE    = 1'b1
) (
  input  wire logic                    mclk,
  input  wire logic                    rstn,
  input  wire logic                    ins_valid,
  input  wire cea_pkg::cea_op_e        ins_op,
  input  wire cea_pkg::cea_mode_e      ins_mode,
  input  wire logic [3:0]              ins_src,
  input  wire logic [3:0]              ins_dst,
  input  wire logic                    ins_byte,
  input  wire logic [`CEA_AW-1:0]      ins_pc,
  input  wire logic [`CEA_AW-1:0]      ins_next_pc,
  input  wire logic [15:0]             ins_index,
  input  wire logic [`CEA_AW-1:0]      ins_target,
  input  wire logic                    cond_true,
  input  wire logic [`CEA_AW-1:0]      src_val,
  input  wire logic [`CEA_AW-1:0]      sp_val,
  input  wire logic [`CEA_AW-1:0]      sp_word,
  input  wire logic [`CEA_AW-1:0]      base_val,
  input  wire logic [15:0]             bit_src,
  input  wire logic [`CEA_TR_AW-1:0]   trace_rd_addr,
  output logic                         sp_wr_r,
  output logic [`CEA_AW-1:0]           sp_data_r,
  output logic                         push_wr_r,
  output logic [`CEA_AW-1:0]           push_data_r,
  output logic                         call_wr_r,
  output logic [`CEA_AW-1:0]           call_ea_r,
  output logic                         flags_wr_r,
  output logic [3:0]                   flags_r,
  output logic                         halted_r,
  output logic [`CEA_TR_AW-1:0]        trace_ptr_r,
  output logic [`CEA_AW-1:0]           trace_rd_data_r
);

  cea_pkg::cea_st_e st_r;
  logic             prev_nt_r;
  logic             prev_mstore_r;
  logic             loop_exit_r;
  logic [`CEA_AW-1:0] loop_head_r;

  // instruction class decode
  wire run_ok    = ins_valid && (st_r == cea_pkg::cea_st_run);
  wire is_pusha  = ins_op == cea_pkg::cea_op_stack_store_addr_ext;
  wire is_pushw  = ins_op == cea_pkg::cea_op_stack_store_word;
  wire is_call   = ins_op == cea_pkg::cea_op_subroutine_jump_20bit;
  wire is_br     = ins_op == cea_pkg::cea_op_branch_cond;
  wire is_rot    = ins_op == cea_pkg::cea_op_rotate_shift_multi;
  wire is_bit    = ins_op == cea_pkg::cea_op_bit_test;
  wire dst_pc    = ins_dst == `CEA_REG_PC;
  wire dst_sp    = ins_dst == `CEA_REG_SP;
  wire mem_mode  = (ins_mode == cea_pkg::cea_md_absolute) ||
                   (ins_mode == cea_pkg::cea_md_symbolic) ||
                   (ins_mode == cea_pkg::cea_md_indexed)  ||
                   (ins_mode == cea_pkg::cea_md_indirect) ||
                   (ins_mode == cea_pkg::cea_md_ind_inc);

  // stack store: normal decrement or stack word taken as new sp
  wire sp_self   = is_pusha && (ins_mode == cea_pkg::cea_md_ind_inc) &&
                   (ins_src == `CEA_REG_SP);
  wire [`CEA_AW-1:0] push_dec = is_pusha ? `CEA_PUSH_A_DEC : `CEA_PUSH_W_DEC;
  wire [`CEA_AW-1:0] sp_store = (ANOM_SP_PUSH && sp_self) ? sp_word
                                                          : sp_val - push_dec;

  // 20-bit call: return address and indexed effective address
  wire call_pc   = is_call && (ins_mode == cea_pkg::cea_md_register) && dst_pc;
  wire [`CEA_AW-1:0] ret_addr = (ANOM_CALL_PC && call_pc)
                                ? ins_next_pc - `CEA_CALL_PC_OFS
                                : ins_next_pc;
  wire idx_bad   = ANOM_CALL_IDX && dst_sp && prev_mstore_r;
  wire [`CEA_AW-1:0] idx_ext  = idx_bad ? {4'h0, ins_index}
                                        : {{4{ins_index[15]}}, ins_index};
  wire [`CEA_AW-1:0] idx_base = dst_sp ? sp_val : base_val;
  wire [`CEA_AW-1:0] call_ea  = (ins_mode == cea_pkg::cea_md_indexed)
                                ? idx_base + idx_ext
                                : (call_pc ? ins_next_pc : src_val);

  // bit test with pc destination: pc seen without its opcode bytes
  wire bit_pc    = is_bit && (ins_mode == cea_pkg::cea_md_indirect) && dst_pc;
  wire [`CEA_AW-1:0] pc_opnd  = (ANOM_BIT_PC && bit_pc) ? ins_pc
                                                        : ins_pc + `CEA_BIT_OPC_LEN;
  wire [15:0] bit_res  = bit_src & pc_opnd[15:0];
  wire        bit_zero = ins_byte ? (bit_res[7:0] == 8'h00) : (bit_res == 16'h0000);
  wire        bit_neg  = ins_byte ? bit_res[7] : bit_res[15];
  wire [3:0]  bit_flags;
  assign bit_flags[`CEA_FLAG_C] = ~bit_zero;
  assign bit_flags[`CEA_FLAG_Z] = bit_zero;
  assign bit_flags[`CEA_FLAG_N] = bit_neg;
  assign bit_flags[`CEA_FLAG_V] = 1'b0;

  // halt on rotate of pc straight after an untaken branch
  wire halt_hit  = ANOM_ROT_HALT && is_rot && dst_pc && prev_nt_r;

  // trace entry: loop head shown in place of the real next instruction
  wire br_nt     = is_br && !cond_true;
  wire tr_we     = run_ok;
  wire [`CEA_AW-1:0] tr_wdata = (ANOM_TRACE && loop_exit_r) ? loop_head_r
                                                            : ins_pc;

  // run/halt state, halt holds until reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r <= cea_pkg::cea_st_run;
    end else begin
      unique case (st_r)
        cea_pkg::cea_st_run: begin
          if (run_ok && halt_hit) begin
            st_r <= cea_pkg::cea_st_halt;
          end
        end
        cea_pkg::cea_st_halt: begin
          st_r <= cea_pkg::cea_st_halt;
        end
      endcase
    end
  end

  // memory of the previous retired instruction; any nop between clears it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prev_nt_r     <= 1'b0;
      prev_mstore_r <= 1'b0;
      loop_exit_r   <= 1'b0;
      loop_head_r   <= `CEA_ADDR_RST;
    end else if (run_ok) begin
      prev_nt_r     <= br_nt;
      prev_mstore_r <= (is_pusha || is_pushw) && mem_mode;
      loop_exit_r   <= br_nt && (ins_target < ins_pc);
      loop_head_r   <= ins_target;
    end
  end

  // stack and call outputs
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sp_wr_r     <= 1'b0;
      sp_data_r   <= `CEA_ADDR_RST;
      push_wr_r   <= 1'b0;
      push_data_r <= `CEA_ADDR_RST;
      call_wr_r   <= 1'b0;
      call_ea_r   <= `CEA_ADDR_RST;
    end else begin
      sp_wr_r     <= run_ok && (is_pusha || is_pushw || is_call);
      sp_data_r   <= is_call ? sp_val - `CEA_PUSH_A_DEC : sp_store;
      push_wr_r   <= run_ok && (is_pusha || is_pushw || is_call);
      push_data_r <= is_call ? ret_addr : (sp_self ? sp_word : src_val);
      call_wr_r   <= run_ok && is_call;
      call_ea_r   <= call_ea;
    end
  end

  // flag update, halt indication and trace pointer
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flags_wr_r  <= 1'b0;
      flags_r     <= `CEA_FLAGS_RST;
      halted_r    <= 1'b0;
      trace_ptr_r <= `CEA_PTR_RST;
    end else begin
      flags_wr_r  <= run_ok && is_bit;
      flags_r     <= (run_ok && is_bit) ? bit_flags : flags_r;
      halted_r    <= (st_r == cea_pkg::cea_st_halt) || (run_ok && halt_hit);
      trace_ptr_r <= tr_we ? trace_ptr_r + 4'h1 : trace_ptr_r;
    end
  end

  // trace state storage
  cea_trace_mem u_trace (
    .mclk      (mclk),
    .rstn      (rstn),
    .wr_en     (tr_we),
    .wr_addr   (trace_ptr_r),
    .wr_data   (tr_wdata),
    .rd_addr   (trace_rd_addr),
    .rd_data_r (trace_rd_data_r)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // single-cycle sequences for the multi-step properties
  sequence mstore_s;
    run_ok && (is_pusha || is_pushw) && mem_mode;
  endsequence
  sequence call_sp_idx_s;
    run_ok && is_call && (ins_mode == cea_pkg::cea_md_indexed) && dst_sp;
  endsequence
  sequence nt_branch_s;
    run_ok && br_nt;
  endsequence
  sequence rot_pc_s;
    run_ok && is_rot && dst_pc;
  endsequence
  // idle cycle between two retired instructions keeps the history
  sequence gap_s;
    !ins_valid;
  endsequence

  sp_push_self_a: assert property (
    (ANOM_SP_PUSH && run_ok && sp_self) |=> (sp_wr_r && sp_data_r == $past(sp_word)))
    else $error("sp not loaded from stack word");

  call_pc_ret_a: assert property (
    (ANOM_CALL_PC && run_ok && call_pc) |=>
      (push_wr_r && push_data_r == $past(ins_next_pc) - `CEA_CALL_PC_OFS))
    else $error("call via pc saved wrong return");

  call_idx_zext_a: assert property (
    (((ANOM_CALL_IDX ##0 mstore_s) ##1 call_sp_idx_s) or
     ((ANOM_CALL_IDX ##0 mstore_s) ##1 gap_s ##1 call_sp_idx_s)) |=>
      (call_wr_r && call_ea_r == $past(sp_val) + {4'h0, $past(ins_index)}))
    else $error("index not treated unsigned");

  call_idx_sext_a: assert property (
    (run_ok && is_call && (ins_mode == cea_pkg::cea_md_indexed) && !dst_sp) |=>
      (call_ea_r == $past(base_val) + {{4{$past(ins_index[15])}}, $past(ins_index)}))
    else $error("index not sign extended");

  rot_halt_a: assert property (
    (((ANOM_ROT_HALT ##0 nt_branch_s) ##1 rot_pc_s) or
     ((ANOM_ROT_HALT ##0 nt_branch_s) ##1 gap_s ##1 rot_pc_s)) |=> halted_r [*3])
    else $error("no halt after branch and rotate");

  halt_quiet_a: assert property (
    halted_r |=> (halted_r && !sp_wr_r && !call_wr_r && !flags_wr_r))
    else $error("activity while halted");

  bit_pc_flags_a: assert property (
    (ANOM_BIT_PC && run_ok && bit_pc && !ins_byte) |=>
      (flags_wr_r && flags_r[`CEA_FLAG_Z] ==
       (($past(bit_src) & $past(ins_pc[15:0])) == 16'h0000)))
    else $error("bit test used corrected pc");

  trace_loop_a: assert property (
    (ANOM_TRACE && run_ok && br_nt && (ins_target < ins_pc)) ##1 run_ok |->
      (tr_we && tr_wdata == $past(ins_target)))
    else $error("loop exit not traced as loop head");

  trace_gap_a: assert property (
    (ANOM_TRACE && run_ok && br_nt && (ins_target < ins_pc)) ##1 gap_s ##1 run_ok |->
      (tr_we && tr_wdata == $past(ins_target, 2)))
    else $error("loop exit after idle not traced as loop head");

endmodule

// ### cea_stack_model.sv
// stack memory model: answers the word at the stack pointer, stores pushed words
// assumes a push lands at the new stack pointer given with the same pulse
`timescale 1ns/10ps
module cea_stack_model (
  input  wire logic        mclk,
  input  wire logic [19:0] sp_val,
  input  wire logic        push_wr,
  input  wire logic [19:0] push_addr,
  input  wire logic [19:0] push_data,
  output logic      [19:0] sp_word
);
  logic [19:0] mem [0:15];
  // known fill so that a stack read is recognisable
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 20'hA0000 | 20'(i);
  end
  // word at the stack pointer, word indexed
  assign sp_word = mem[sp_val[4:1]];
  // pushed words overwrite their slot
  always @(posedge mclk) begin
    if (push_wr) mem[push_addr[4:1]] <= push_data;
  end
endmodule

// ### tb_cea_exec.sv
// directed scenarios for the execution anomaly block, one task each
// assumes cea_pkg, cea_map.svh and the stack model are compiled first
`include "cea_map.svh"
`timescale 1ns/10ps
module tb_cea_exec;
  localparam cea_pkg::cea_op_e   op_nop = cea_pkg::cea_op_nop;
  localparam cea_pkg::cea_op_e   op_pa  = cea_pkg::cea_op_stack_store_addr_ext;
  localparam cea_pkg::cea_op_e   op_pw  = cea_pkg::cea_op_stack_store_word;
  localparam cea_pkg::cea_op_e   op_cl  = cea_pkg::cea_op_subroutine_jump_20bit;
  localparam cea_pkg::cea_op_e   op_br  = cea_pkg::cea_op_branch_cond;
  localparam cea_pkg::cea_op_e   op_rot = cea_pkg::cea_op_rotate_shift_multi;
  localparam cea_pkg::cea_op_e   op_bit = cea_pkg::cea_op_bit_test;
  localparam cea_pkg::cea_op_e   op_oth = cea_pkg::cea_op_other;
  localparam cea_pkg::cea_mode_e md_reg = cea_pkg::cea_md_register;
  localparam cea_pkg::cea_mode_e md_idx = cea_pkg::cea_md_indexed;
  localparam cea_pkg::cea_mode_e md_abs = cea_pkg::cea_md_absolute;
  logic               mclk = 1'b0;
  logic               rstn = 1'b0;
  logic               ins_valid = 1'b0;
  cea_pkg::cea_op_e   ins_op = op_nop;
  cea_pkg::cea_mode_e ins_mode = md_reg;
  logic [3:0]         ins_src = 4'h0;
  logic [3:0]         ins_dst = 4'h0;
  logic [19:0]        ins_pc = 20'h08000;
  logic [19:0]        ins_next_pc = 20'h08004;
  logic [15:0]        ins_index = 16'h0000;
  logic [19:0]        ins_target = 20'h00000;
  logic               cond_true = 1'b0;
  logic               ins_byte = 1'b0;
  logic [3:0]         trace_rd_addr = 4'h0;
  logic [19:0]        sp_word, sp_data_r, push_data_r, call_ea_r, trace_rd_data_r;
  logic               sp_wr_r, push_wr_r, call_wr_r, flags_wr_r, halted_r;
  logic [3:0]         flags_r, trace_ptr_r, exp_ptr;
  logic               halt_exp;
  int                 failures = 0;
  int                 cmp_count = 0;

  cea_exec cea_exec_inst (.mclk(mclk), .rstn(rstn), .ins_valid(ins_valid), .ins_op(ins_op),
    .ins_mode(ins_mode), .ins_src(ins_src), .ins_dst(ins_dst), .ins_byte(ins_byte),
    .ins_pc(ins_pc), .ins_next_pc(ins_next_pc), .ins_index(ins_index),
    .ins_target(ins_target), .cond_true(cond_true), .src_val(20'h12345),
    .sp_val(20'h02000), .sp_word(sp_word), .base_val(20'h03000), .bit_src(16'h0002),
    .trace_rd_addr(trace_rd_addr), .sp_wr_r(sp_wr_r), .sp_data_r(sp_data_r),
    .push_wr_r(push_wr_r), .push_data_r(push_data_r), .call_wr_r(call_wr_r),
    .call_ea_r(call_ea_r), .flags_wr_r(flags_wr_r), .flags_r(flags_r),
    .halted_r(halted_r), .trace_ptr_r(trace_ptr_r), .trace_rd_data_r(trace_rd_data_r));
  cea_stack_model cea_stack_model_inst (.mclk(mclk), .sp_val(20'h02000),
    .push_wr(push_wr_r), .push_addr(sp_data_r), .push_data(push_data_r), .sp_word(sp_word));

  // free running clock
  always #5 mclk = ~mclk;

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task end_of_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task do_reset;
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    exp_ptr = 4'h0;
    halt_exp = 1'b0;
  endtask

  // one instruction: driven at an edge, taken at the next, outputs read just after
  task automatic send(input cea_pkg::cea_op_e op, input cea_pkg::cea_mode_e md,
                      input logic [3:0] src, input logic [3:0] dst,
                      input logic [19:0] pc, input logic [19:0] aux);
    @(posedge mclk);
    ins_valid <= 1'b1;
    ins_op <= op;
    ins_mode <= md;
    ins_src <= src;
    ins_dst <= dst;
    ins_pc <= pc;
    ins_next_pc <= pc + 20'h00004;
    ins_index <= aux[15:0];
    ins_target <= aux;
    @(posedge mclk);
    ins_valid <= 1'b0;
    #1;
    if (!halt_exp) exp_ptr = exp_ptr + 4'h1;
  endtask

  task automatic rd_trace(input logic [3:0] idx, input logic [19:0] exp);
    @(posedge mclk);
    trace_rd_addr <= idx;
    @(posedge mclk);
    #1;
    chk(trace_rd_data_r, exp);
  endtask

  task t_push;
    send(op_pa, cea_pkg::cea_md_ind_inc, 4'h1, 4'h0, 20'h08000, 20'h0);
    chk(sp_wr_r, 1'b1);
    chk(sp_data_r, 20'hA0000);
    send(op_pa, md_reg, 4'h5, 4'h0, 20'h08004, 20'h0);
    chk(sp_data_r, 20'h01FFC);
    chk(push_data_r, 20'h12345);
    $display("push done");
  endtask

  task t_call;
    send(op_cl, md_reg, 4'h0, 4'h0, 20'h09000, 20'h0);
    chk(call_wr_r, 1'b1);
    chk(push_wr_r, 1'b1);
    chk(push_data_r, 20'h09002);
    chk(sp_data_r, 20'h01FFC);
    for (int m = 0; m < 7; m++) begin
      send(op_pw, cea_pkg::cea_mode_e'(m), 4'h5, 4'h0, 20'h09010, 20'h0);
      chk(sp_data_r, 20'h01FFE);
      send(op_cl, md_idx, 4'h0, 4'h1, 20'h09014, 20'h0FFFC);
      chk(call_ea_r, (m >= 1 && m <= 5) ? 20'h11FFC : 20'h01FFC);
    end
    send(op_pw, md_abs, 4'h5, 4'h0, 20'h09020, 20'h0);
    send(op_nop, md_reg, 4'h0, 4'h0, 20'h09024, 20'h0);
    send(op_cl, md_idx, 4'h0, 4'h1, 20'h09026, 20'h0FFFC);
    chk(call_ea_r, 20'h01FFC);
    send(op_pw, md_abs, 4'h5, 4'h0, 20'h09030, 20'h0);
    send(op_cl, md_idx, 4'h0, 4'h4, 20'h09034, 20'h0FFFC);
    chk(call_ea_r, 20'h02FFC);
    $display("call done");
  endtask

  task t_bit;
    send(op_bit, cea_pkg::cea_md_indirect, 4'h5, 4'h0, 20'h08001, 20'h0);
    chk(flags_wr_r, 1'b1);
    chk(flags_r, 4'h2);
    send(op_bit, md_reg, 4'h5, 4'h0, 20'h08001, 20'h0);
    chk(flags_r, 4'h1);
    @(posedge mclk);
    ins_byte <= 1'b1;
    send(op_bit, cea_pkg::cea_md_indirect, 4'h5, 4'h0, 20'h08001, 20'h0);
    chk(flags_r, 4'h2);
    @(posedge mclk);
    ins_byte <= 1'b0;
    $display("bit test done");
  endtask

  task t_trace;
    logic [3:0] p;
    p = exp_ptr;
    send(op_br, md_reg, 4'h0, 4'h0, 20'h08016, 20'h08012);
    send(op_oth, md_reg, 4'h0, 4'h0, 20'h08018, 20'h0);
    send(op_br, md_reg, 4'h0, 4'h0, 20'h08020, 20'h08030);
    send(op_oth, md_reg, 4'h0, 4'h0, 20'h08022, 20'h0);
    chk(trace_ptr_r, exp_ptr);
    rd_trace(p, 20'h08016);
    rd_trace(p + 4'h1, 20'h08012);
    rd_trace(p + 4'h3, 20'h08022);
    $display("trace done");
  endtask

  task t_halt;
    @(posedge mclk);
    cond_true <= 1'b1;
    send(op_br, md_reg, 4'h0, 4'h0, 20'h08030, 20'h08060);
    send(op_rot, md_reg, 4'h0, 4'h0, 20'h08032, 20'h0);
    chk(halted_r, 1'b0);
    @(posedge mclk);
    cond_true <= 1'b0;
    send(op_br, md_reg, 4'h0, 4'h0, 20'h08040, 20'h08060);
    send(op_nop, md_reg, 4'h0, 4'h0, 20'h08042, 20'h0);
    send(op_rot, md_reg, 4'h0, 4'h0, 20'h08044, 20'h0);
    chk(halted_r, 1'b0);
    send(op_br, md_reg, 4'h0, 4'h0, 20'h08050, 20'h08060);
    send(op_rot, md_reg, 4'h0, 4'h0, 20'h08052, 20'h0);
    chk(halted_r, 1'b1);
    halt_exp = 1'b1;
    send(op_cl, md_reg, 4'h0, 4'h0, 20'h08054, 20'h0);
    chk(call_wr_r, 1'b0);
    chk(trace_ptr_r, exp_ptr);
    do_reset;
    #1;
    chk(halted_r, 1'b0);
    $display("halt done");
  endtask

  // watchdog cuts a hang short
  initial begin
    #200000;
    failures++;
    end_of_test;
  end

  initial begin
    do_reset;
    t_push;
    t_call;
    t_bit;
    t_trace;
    t_halt;
    end_of_test;
  end
endmodule
